// ===== hw/status_tracker_defines.svh
// Behaviour
// RULE1: suspend-any flag is status two bit 7
// RULE2: erase-suspended flag is status five bit 3
// RULE3: program-suspended flag is status five bit 2
// RULE4: suspend-any equals erase-suspended OR program-suspended
// RULE5: resumed program completion clears program-suspended
// RULE6: resumed erase completion clears erase-suspended
// RULE7: all three set means program inside erase
// RULE8: program may start and suspend within erase suspend
// RULE9: host never suspends erase inside program suspend
// RULE10: host finishes inner program before resuming erase
// RULE11: erase error sets status four bit 4
// RULE12: program error sets status four bit 5
// RULE13: accepted erase command clears erase-error flag
// RULE14: accepted program-type command clears program-error flag
// RULE15: status register writes may set program-error
// RULE16: error flags hold while operation suspended
// RULE17: resume leaves both error flags unchanged
// RULE18: terminate of running operation sets matching error
// RULE19: any device reset clears both error flags
// RULE20: waking from deep sleep keeps error flags
// RULE21: waking from deepest sleep resets, clearing flags
// RULE22: host checks error flags after each operation
// RULE23: terminate during suspend sequence wins, no suspend flag
// RULE24: terminate ignored during register write, lock, OTP
// RULE25: flags are read-only over the register port
`ifndef STATUS_TRACKER_DEFINES_SVH
`define STATUS_TRACKER_DEFINES_SVH
`define SR1_OFS 8'h00
`define SR2_OFS 8'h04
`define SR3_OFS 8'h08
`define SR4_OFS 8'h0C
`define SR5_OFS 8'h10
`define BUSY_BIT 0
`define ASU_BIT 7
`define ESU_BIT 3
`define PSU_BIT 2
`define EER_BIT 4
`define PER_BIT 5
`define PDM_BIT 7
`define PDM_RST 1'b0
`endif

// ===== hw/status_tracker_pkg.sv
package status_tracker_pkg;
    typedef enum logic [7:0] {
        op_erase_4k = 8'h20, op_erase_32k = 8'h52, op_erase_64k = 8'hD8, op_chip_a = 8'h60,
        op_chip_b = 8'hC7, op_prog = 8'h02, op_prog_dual = 8'hA2, op_prog_quad = 8'h32,
        op_seq_a = 8'hAD, op_seq_b = 8'hAF, op_otp_prog = 8'h9B, op_wrsr_a = 8'h01,
        op_wrsr_b = 8'h31, op_wrsr_c = 8'h11, op_wrsr_ind = 8'h71, op_sr_lock = 8'h6F,
        op_pause_a = 8'hB0, op_pause_b = 8'h75, op_resume_a = 8'hD0, op_resume_b = 8'h7A,
        op_term = 8'hF0, op_rst_en = 8'h66, op_rst = 8'h99, op_sleep = 8'hB9,
        op_sleep_deepest = 8'h79, op_wake = 8'hAB
    } opcode_t;

    typedef enum logic [2:0] {
        st_idle, st_prog, st_erase, st_special, st_prog_pause, st_erase_pause
    } eng_t;
endpackage

// ===== hw/status_tracker_if.sv
`timescale 1ns/1ps
interface cmd_class_if;
    logic erase;
    logic prog;
    logic special;
    logic pause;
    logic resume;
    logic term;
    logic rst_en;
    logic rst;
    logic sleep;
    logic sleep_deepest;
    logic wake;
    modport dec (output erase, prog, special, pause, resume, term, rst_en, rst, sleep, sleep_deepest, wake);
    modport use_side (input erase, prog, special, pause, resume, term, rst_en, rst, sleep, sleep_deepest, wake);
endinterface

interface status_if;
    logic busy;
    logic psu;
    logic esu;
    logic asu;
    logic eer;
    logic per;
    logic pdm;
    modport rf (input busy, psu, esu, asu, eer, per, output pdm);
    modport core (output busy, psu, esu, asu, eer, per, input pdm);
endinterface

// ===== hw/cmd_decoder.sv
`timescale 1ns/1ps
module cmd_decoder (
    input wire logic [7:0] cmd_code,
    cmd_class_if.dec cls
);
    always_comb
    begin
        cls.erase = cmd_code inside {status_tracker_pkg::op_erase_4k, status_tracker_pkg::op_erase_32k,
            status_tracker_pkg::op_erase_64k, status_tracker_pkg::op_chip_a, status_tracker_pkg::op_chip_b};
        cls.prog = cmd_code inside {status_tracker_pkg::op_prog, status_tracker_pkg::op_prog_dual,
            status_tracker_pkg::op_prog_quad, status_tracker_pkg::op_seq_a, status_tracker_pkg::op_seq_b};
        // non-volatile register operations: terminate cannot stop them
        cls.special = cmd_code inside {status_tracker_pkg::op_otp_prog, status_tracker_pkg::op_wrsr_a,
            status_tracker_pkg::op_wrsr_b, status_tracker_pkg::op_wrsr_c, status_tracker_pkg::op_wrsr_ind,
            status_tracker_pkg::op_sr_lock};
        cls.pause = cmd_code inside {status_tracker_pkg::op_pause_a, status_tracker_pkg::op_pause_b};
        cls.resume = cmd_code inside {status_tracker_pkg::op_resume_a, status_tracker_pkg::op_resume_b};
        cls.term = cmd_code == status_tracker_pkg::op_term;
        cls.rst_en = cmd_code == status_tracker_pkg::op_rst_en;
        cls.rst = cmd_code == status_tracker_pkg::op_rst;
        cls.sleep = cmd_code == status_tracker_pkg::op_sleep;
        cls.sleep_deepest = cmd_code == status_tracker_pkg::op_sleep_deepest;
        cls.wake = cmd_code == status_tracker_pkg::op_wake;
    end
endmodule

// ===== hw/status_regfile.sv
`timescale 1ns/1ps
`include "status_tracker_defines.svh"
module status_regfile #(
    parameter int ADDR_W = 8
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    status_if.rf st
);
    logic pdm_r;
    logic pdm_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb
    begin
        pdm_nxt = pdm_r;
        rdata_nxt = 8'h00;
        // only the power-down mode bit is writable; flags ignore writes
        if (wr_en && addr == ADDR_W'(`SR4_OFS)) // RULE25
            pdm_nxt = wdata[`PDM_BIT];
        if (rd_en)
        begin
            unique case (addr)
                ADDR_W'(`SR1_OFS): rdata_nxt[`BUSY_BIT] = st.busy;
                ADDR_W'(`SR2_OFS): rdata_nxt[`ASU_BIT] = st.asu; // RULE1
                ADDR_W'(`SR3_OFS): rdata_nxt = 8'h00;
                ADDR_W'(`SR4_OFS):
                begin
                    rdata_nxt[`PDM_BIT] = pdm_r;
                    rdata_nxt[`EER_BIT] = st.eer; // RULE11
                    rdata_nxt[`PER_BIT] = st.per; // RULE12
                end
                ADDR_W'(`SR5_OFS):
                begin
                    rdata_nxt[`ESU_BIT] = st.esu; // RULE2
                    rdata_nxt[`PSU_BIT] = st.psu; // RULE3
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pdm_r <= `PDM_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            pdm_r <= pdm_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign st.pdm = pdm_r;
    assign rdata = rdata_r;
endmodule

// ===== hw/suspend_error_status_tracker.sv
`timescale 1ns/1ps
module suspend_error_status_tracker #(
    parameter int ADDR_W = 8
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic op_done,
    input wire logic op_error,
    input wire logic suspend_done,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic busy,
    output logic deep_sleep_state,
    output logic deepest_sleep_state,
    output logic suspend_any_flag,
    output logic erase_suspended_flag,
    output logic program_suspended_flag,
    output logic erase_error_flag,
    output logic program_error_flag,
    output logic cmd_accepted,
    output logic cmd_ignored
);
    cmd_class_if cls ();
    status_if sts ();

    status_tracker_pkg::eng_t st_r;
    status_tracker_pkg::eng_t st_nxt;
    logic psu_r;
    logic psu_nxt;
    logic esu_r;
    logic esu_nxt;
    logic asu_r;
    logic asu_nxt;
    logic eer_r;
    logic eer_nxt;
    logic per_r;
    logic per_nxt;
    logic deep_r;
    logic deep_nxt;
    logic deepest_r;
    logic deepest_nxt;
    logic arm_r;
    logic arm_nxt;
    logic pend_r;
    logic pend_nxt;
    logic busy_r;
    logic busy_nxt;
    logic acc_r;
    logic acc_nxt;
    logic ign_r;
    logic ign_nxt;
    logic dev_rst;
    logic idle_free;

    cmd_decoder u_dec (
        .cmd_code(cmd_code),
        .cls(cls.dec)
    );

    status_regfile #(
        .ADDR_W(ADDR_W)
    ) u_rf (
        .clk(clk),
        .rst_b(rst_b),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rdata(rdata),
        .st(sts.rf)
    );

    assign idle_free = (st_r == status_tracker_pkg::st_idle);

    always_comb
    begin
        st_nxt = st_r;
        psu_nxt = psu_r;
        esu_nxt = esu_r;
        eer_nxt = eer_r; // RULE16
        per_nxt = per_r; // RULE16
        deep_nxt = deep_r;
        deepest_nxt = deepest_r;
        arm_nxt = arm_r;
        pend_nxt = pend_r;
        acc_nxt = 1'b0;
        ign_nxt = 1'b0;
        dev_rst = 1'b0;
        if (cmd_valid)
            arm_nxt = cls.rst_en;
        if (deep_r || deepest_r)
        begin
            if (cmd_valid && cls.wake)
            begin
                acc_nxt = 1'b1;
                deep_nxt = 1'b0;
                deepest_nxt = 1'b0;
                dev_rst = deepest_r; // RULE20 RULE21
            end
            else if (cmd_valid && cls.rst && arm_r && deep_r)
            begin
                acc_nxt = 1'b1;
                dev_rst = 1'b1; // RULE19
            end
            else if (cmd_valid && !cls.rst_en)
                ign_nxt = 1'b1;
        end
        else
        begin
            // sequencer events of the running operation
            unique case (st_r)
                status_tracker_pkg::st_idle:
                begin
                end
                status_tracker_pkg::st_prog:
                begin
                    if (op_error)
                        per_nxt = 1'b1; // RULE12
                    if (op_done)
                    begin
                        st_nxt = status_tracker_pkg::st_idle;
                        psu_nxt = 1'b0; // RULE5
                    end
                end
                status_tracker_pkg::st_erase:
                begin
                    if (op_error)
                        eer_nxt = 1'b1; // RULE11
                    if (op_done)
                    begin
                        st_nxt = status_tracker_pkg::st_idle;
                        esu_nxt = 1'b0; // RULE6
                    end
                end
                status_tracker_pkg::st_special:
                begin
                    if (op_error)
                        per_nxt = 1'b1; // RULE15
                    if (op_done)
                    begin
                        st_nxt = status_tracker_pkg::st_idle;
                        dev_rst = pend_r;
                    end
                end
                status_tracker_pkg::st_prog_pause:
                begin
                    if (suspend_done)
                    begin
                        st_nxt = status_tracker_pkg::st_idle;
                        psu_nxt = 1'b1; // RULE3 RULE8
                    end
                end
                status_tracker_pkg::st_erase_pause:
                begin
                    if (suspend_done)
                    begin
                        st_nxt = status_tracker_pkg::st_idle;
                        esu_nxt = 1'b1; // RULE2
                    end
                end
            endcase
            if (cmd_valid)
            begin
                if (cls.term)
                begin
                    // a stopped operation cannot be resumed, so its suspend flag goes too
                    if (st_r == status_tracker_pkg::st_prog || st_r == status_tracker_pkg::st_prog_pause)
                    begin
                        per_nxt = 1'b1; // RULE18
                        psu_nxt = 1'b0; // RULE23
                        st_nxt = status_tracker_pkg::st_idle;
                        acc_nxt = 1'b1;
                    end
                    else if (st_r == status_tracker_pkg::st_erase || st_r == status_tracker_pkg::st_erase_pause)
                    begin
                        eer_nxt = 1'b1; // RULE18
                        esu_nxt = 1'b0; // RULE23
                        st_nxt = status_tracker_pkg::st_idle;
                        acc_nxt = 1'b1;
                    end
                    else
                        ign_nxt = 1'b1; // RULE24
                end
                else if (cls.pause)
                begin
                    acc_nxt = 1'b1;
                    if (st_r == status_tracker_pkg::st_prog)
                        st_nxt = status_tracker_pkg::st_prog_pause;
                    else if (st_r == status_tracker_pkg::st_erase)
                        st_nxt = status_tracker_pkg::st_erase_pause;
                    else
                    begin
                        acc_nxt = 1'b0;
                        ign_nxt = 1'b1;
                    end
                end
                else if (cls.rst_en)
                    acc_nxt = 1'b1;
                else if (cls.rst)
                begin
                    acc_nxt = arm_r;
                    ign_nxt = !arm_r;
                    // non-volatile register updates finish before the reset lands
                    if (arm_r && st_r == status_tracker_pkg::st_special)
                        pend_nxt = 1'b1;
                    else if (arm_r)
                        dev_rst = 1'b1; // RULE19
                end
                else if (cls.resume)
                begin
                    // inner program first, then the outer erase
                    acc_nxt = idle_free && (psu_r || esu_r);
                    ign_nxt = !(idle_free && (psu_r || esu_r));
                    if (idle_free && psu_r)
                        st_nxt = status_tracker_pkg::st_prog; // RULE10 RULE17
                    else if (idle_free && esu_r)
                        st_nxt = status_tracker_pkg::st_erase; // RULE17
                end
                else if (cls.erase)
                begin
                    // no erase while anything is suspended
                    acc_nxt = idle_free && !psu_r && !esu_r; // RULE9
                    ign_nxt = !acc_nxt;
                    if (acc_nxt)
                    begin
                        eer_nxt = 1'b0; // RULE13
                        st_nxt = status_tracker_pkg::st_erase;
                    end
                end
                else if (cls.prog)
                begin
                    acc_nxt = idle_free && !psu_r; // RULE8
                    ign_nxt = !acc_nxt;
                    if (acc_nxt)
                    begin
                        per_nxt = 1'b0; // RULE14
                        st_nxt = status_tracker_pkg::st_prog;
                    end
                end
                else if (cls.special)
                begin
                    acc_nxt = idle_free && !psu_r && !esu_r;
                    ign_nxt = !acc_nxt;
                    if (acc_nxt)
                    begin
                        per_nxt = 1'b0; // RULE14
                        st_nxt = status_tracker_pkg::st_special;
                    end
                end
                else if (cls.sleep || cls.sleep_deepest)
                begin
                    acc_nxt = idle_free && !psu_r && !esu_r;
                    ign_nxt = !acc_nxt;
                    if (acc_nxt)
                    begin
                        deep_nxt = cls.sleep && sts.pdm;
                        deepest_nxt = !(cls.sleep && sts.pdm);
                    end
                end
                else if (cls.wake)
                    ign_nxt = 1'b1;
            end
        end
        if (dev_rst)
        begin
            st_nxt = status_tracker_pkg::st_idle;
            psu_nxt = 1'b0;
            esu_nxt = 1'b0;
            eer_nxt = 1'b0; // RULE19 RULE21
            per_nxt = 1'b0; // RULE19 RULE21
            deep_nxt = 1'b0;
            deepest_nxt = 1'b0;
            arm_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
        asu_nxt = psu_nxt || esu_nxt; // RULE4 RULE7
        busy_nxt = (st_nxt != status_tracker_pkg::st_idle);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= status_tracker_pkg::st_idle;
            psu_r <= 1'b0;
            esu_r <= 1'b0;
            asu_r <= 1'b0;
            eer_r <= 1'b0;
            per_r <= 1'b0;
            deep_r <= 1'b0;
            deepest_r <= 1'b0;
            arm_r <= 1'b0;
            pend_r <= 1'b0;
            busy_r <= 1'b0;
            acc_r <= 1'b0;
            ign_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            psu_r <= psu_nxt;
            esu_r <= esu_nxt;
            asu_r <= asu_nxt;
            eer_r <= eer_nxt;
            per_r <= per_nxt;
            deep_r <= deep_nxt;
            deepest_r <= deepest_nxt;
            arm_r <= arm_nxt;
            pend_r <= pend_nxt;
            busy_r <= busy_nxt;
            acc_r <= acc_nxt;
            ign_r <= ign_nxt;
        end
    end

    assign sts.busy = busy_r;
    assign sts.psu = psu_r;
    assign sts.esu = esu_r;
    assign sts.asu = asu_r;
    assign sts.eer = eer_r;
    assign sts.per = per_r;
    assign busy = busy_r;
    assign deep_sleep_state = deep_r;
    assign deepest_sleep_state = deepest_r;
    assign suspend_any_flag = asu_r;
    assign erase_suspended_flag = esu_r;
    assign program_suspended_flag = psu_r;
    assign erase_error_flag = eer_r;
    assign program_error_flag = per_r;
    assign cmd_accepted = acc_r;
    assign cmd_ignored = ign_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic awake;
    assign awake = !deep_r && !deepest_r;

    suspend_any_flag_or_a: assert property (suspend_any_flag == (erase_suspended_flag || program_suspended_flag)) // RULE4
        else $error("suspend-any differs from the OR of the two suspend flags");
    prog_pause_a: assert property (awake && st_r == status_tracker_pkg::st_prog_pause && suspend_done // RULE3
        && !cmd_valid |=> program_suspended_flag && suspend_any_flag && !busy)
        else $error("program suspend did not raise its flag");
    erase_pause_a: assert property (awake && st_r == status_tracker_pkg::st_erase_pause && suspend_done // RULE2
        && !cmd_valid |=> erase_suspended_flag && suspend_any_flag)
        else $error("erase suspend did not raise its flag");
    prog_done_a: assert property (awake && st_r == status_tracker_pkg::st_prog && op_done // RULE5
        && !cmd_valid |=> !program_suspended_flag && !busy)
        else $error("program completion left the program-suspended flag");
    erase_done_a: assert property (awake && st_r == status_tracker_pkg::st_erase && op_done // RULE6
        && !cmd_valid |=> !erase_suspended_flag)
        else $error("erase completion left the erase-suspended flag");
    nest_prog_a: assert property (awake && idle_free && esu_r && !psu_r && cmd_valid && cls.prog // RULE8
        |=> cmd_accepted && busy && erase_suspended_flag)
        else $error("program refused during erase suspend");
    erase_clr_a: assert property (awake && idle_free && !psu_r && !esu_r && cmd_valid && cls.erase // RULE13
        |=> !erase_error_flag && busy)
        else $error("accepted erase did not clear the erase-error flag");
    prog_clr_a: assert property (awake && idle_free && !psu_r && cmd_valid // RULE14
        && (cls.prog || cls.special && !esu_r) |=> !program_error_flag)
        else $error("accepted program did not clear the program-error flag");
    resume_hold_a: assert property (awake && idle_free && cmd_valid && cls.resume // RULE17
        |=> $stable(erase_error_flag) && $stable(program_error_flag))
        else $error("resume changed an error flag");
    term_erase_a: assert property (awake && st_r == status_tracker_pkg::st_erase_pause && cmd_valid // RULE23
        && cls.term |=> erase_error_flag && !erase_suspended_flag && !busy)
        else $error("terminate during suspend sequence mishandled");
    term_ignore_a: assert property (st_r == status_tracker_pkg::st_special && cmd_valid && cls.term // RULE24
        && !op_done |=> cmd_ignored && busy)
        else $error("terminate stopped a register write");
    wake_deep_a: assert property (deep_r && cmd_valid && cls.wake // RULE20
        |=> $stable(erase_error_flag) && $stable(program_error_flag) && !deep_sleep_state)
        else $error("deep sleep exit changed an error flag");
    wake_deepest_a: assert property (deepest_r && cmd_valid && cls.wake // RULE21
        |=> !erase_error_flag && !program_error_flag && !suspend_any_flag)
        else $error("deepest sleep exit kept an error flag");
    write_ro_a: assert property (wr_en && !cmd_valid && !op_done && !op_error && !suspend_done // RULE25
        |=> $stable({suspend_any_flag, erase_error_flag, program_error_flag}))
        else $error("register write altered a flag");

    nested_c: cover property (suspend_any_flag && erase_suspended_flag && program_suspended_flag);
    term_c: cover property (st_r == status_tracker_pkg::st_prog && cmd_valid && cls.term);
    deepest_c: cover property (deepest_r && cmd_valid && cls.wake);
    special_err_c: cover property (st_r == status_tracker_pkg::st_special && op_error);
endmodule

// ===== tb/flash_host_model.sv
`timescale 1ns/1ps
// command issuer and array-engine event source
module flash_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic op_done,
    output logic op_error,
    output logic suspend_done
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        op_done = 1'b0;
        op_error = 1'b0;
        suspend_done = 1'b0;
    end
    // released code shows the inverse; for 8'h52 and 8'hAD that inverse is itself another opcode
    task automatic send(input logic [7:0] code);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
    endtask
    // kind 0 done, 1 done with error, 2 suspend finished
    task automatic event_pulse(input int kind, input int lat);
        repeat (lat) @(posedge clk);
        op_done <= (kind != 2);
        op_error <= (kind == 1);
        suspend_done <= (kind == 2);
        @(posedge clk);
        op_done <= 1'b0;
        op_error <= 1'b0;
        suspend_done <= 1'b0;
    endtask
endmodule

// ===== tb/suspend_error_status_tracker_tb.sv
`timescale 1ns/1ps
module suspend_error_status_tracker_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic cmd_valid, op_done, op_error, suspend_done, busy, deep_sleep_state, deepest_sleep_state;
    logic suspend_any_flag, erase_suspended_flag, program_suspended_flag, erase_error_flag;
    logic program_error_flag, cmd_accepted, cmd_ignored, er, x_eer, x_per;
    logic [7:0] cmd_code, rdata;
    logic [7:0] ops [16] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02, 8'hA2, 8'h32,
        8'hAD, 8'hAF, 8'h9B, 8'h01, 8'h31, 8'h11, 8'h71, 8'h6F};
    wire logic [4:0] flags = {suspend_any_flag, erase_suspended_flag, program_suspended_flag,
        erase_error_flag, program_error_flag};
    int n_fail = 0;
    int tests_run = 0;
    int seed = 32'h7EF26414;

    always #12.5 clk = ~clk;

    flash_host_model h (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .op_done(op_done),
        .op_error(op_error), .suspend_done(suspend_done));
    suspend_error_status_tracker DUT (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .op_done(op_done), .op_error(op_error), .suspend_done(suspend_done), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .busy(busy), .deep_sleep_state(deep_sleep_state),
        .deepest_sleep_state(deepest_sleep_state), .suspend_any_flag(suspend_any_flag),
        .erase_suspended_flag(erase_suspended_flag), .program_suspended_flag(program_suspended_flag),
        .erase_error_flag(erase_error_flag), .program_error_flag(program_error_flag),
        .cmd_accepted(cmd_accepted), .cmd_ignored(cmd_ignored));

    function automatic logic [4:0] xf(input logic esu, psu, eer, per);
        return {esu | psu, esu, psu, eer, per};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic fl(input logic [4:0] exp);
        @(posedge clk);
        #1;
        chk("flags", {3'h0, exp}, {3'h0, flags});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #2000000;
        n_fail++;
        wrap_up();
    end

    initial
    begin
        x_eer = 1'b0;
        x_per = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ops[i])
        begin
            er = 1'($random(seed));
            h.send(ops[i]);
            if (i < 5)
                x_eer = 1'b0;
            else
                x_per = 1'b0;
            fl(xf(0, 0, x_eer, x_per));
            h.event_pulse(int'(er), 1 + i % 3);
            if (i < 5)
                x_eer = er;
            else
                x_per = er;
            fl(xf(0, 0, x_eer, x_per));
        end
        h.send(8'h02);
        h.event_pulse(1, 2);
        wr(8'h0C, 8'h00);
        rd(8'h0C, {2'h0, 1'b1, x_eer, 4'h0});
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        $display("error flag tests done");
        h.send(8'h20);
        h.send(8'h75);
        h.event_pulse(2, 2);
        fl(xf(1, 0, 0, 1));
        rd(8'h04, 8'h80);
        h.send(8'h02);
        h.send(8'hB0);
        h.event_pulse(2, 4);
        fl(xf(1, 1, 0, 0));
        rd(8'h10, 8'h0C);
        h.send(8'hD0);
        #1;
        chk("accepted", 8'h01, {7'h0, cmd_accepted});
        fl(xf(1, 1, 0, 0));
        h.event_pulse(0, 3);
        fl(xf(1, 0, 0, 0));
        h.send(8'h7A);
        h.event_pulse(1, 2);
        fl(xf(0, 0, 1, 0));
        $display("nested suspend test done");
        h.send(8'h32);
        h.send(8'hF0);
        fl(xf(0, 0, 1, 1));
        h.send(8'hD8);
        h.send(8'h75);
        h.send(8'hF0);
        fl(xf(0, 0, 1, 1));
        chk("busy", 8'h00, {7'h0, busy});
        h.send(8'h6F);
        h.send(8'hF0);
        #1;
        chk("ignored", 8'h01, {7'h0, cmd_ignored});
        h.event_pulse(0, 1);
        fl(xf(0, 0, 1, 0));
        $display("terminate tests done");
        h.send(8'h02);
        h.event_pulse(1, 1);
        wr(8'h0C, 8'h80);
        h.send(8'hB9);
        #1;
        chk("deep", 8'h01, {7'h0, deep_sleep_state});
        h.send(8'hAB);
        fl(xf(0, 0, 1, 1));
        wr(8'h0C, 8'h00);
        h.send(8'hB9);
        #1;
        chk("deepest", 8'h01, {7'h0, deepest_sleep_state});
        h.send(8'hAB);
        fl(xf(0, 0, 0, 0));
        h.send(8'h20);
        h.event_pulse(1, 1);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        fl(xf(0, 0, 0, 0));
        $display("sleep and reset tests done");
        wrap_up();
    end
endmodule
